// ---- sram_link_pkg.sv ----
// Shared constants and carrier types for the burst SRAM link block.
// Assumes one link beat per rising edge of the merged K/K# beat clock.
package sram_link_pkg;

    localparam int DATA_W    = 36;
    localparam int LANE_W    = 9;
    localparam int LANES     = DATA_W / LANE_W;
    localparam int ADDR_W    = 8;
    localparam int BURST_LEN = 4;

    // Beat slots within one four-beat frame (two K cycles), and the index of the last word of a burst
    localparam logic [1:0] RD_SLOT = 2'h0;
    localparam logic [1:0] WR_SLOT = 2'h2;
    localparam logic [1:0] LAST_WORD = 2'h3;

    // Read latency in beats: two beats per K cycle
    localparam int LAT_HI_BEATS = 5;
    localparam int LAT_LO_BEATS = 2;
    localparam int PIPE_LEN     = LAT_HI_BEATS - 1;

    typedef struct packed {
        logic                 rd_sel;
        logic                 wr_sel;
        logic [ADDR_W-1:0]    addr;
        logic [LANES-1:0]     lane_we;
        logic [DATA_W-1:0]    data;
        logic [1:0]           beat;
    } link_in_t;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
    } rd_req_t;

    typedef struct packed {
        link_in_t                               in;
        logic [1:0]                             beat;
        rd_req_t [PIPE_LEN-1:0]                 rd_pipe;
        logic                                   rd_act;
        logic [1:0]                             rd_idx;
        logic [ADDR_W-1:0]                      rd_addr;
        logic                                   wr_act;
        logic [1:0]                             wr_idx;
        logic [ADDR_W-1:0]                      wr_addr;
        logic [BURST_LEN-2:0][DATA_W-1:0]       wr_buf;
        logic [BURST_LEN-2:0][LANES-1:0]        wr_mask;
        logic [DATA_W-1:0]                      rdata;
        logic                                   rvalid;
        logic                                   echo;
        logic                                   echo_n;
        logic [1:0]                             lat_sync;
    } link_state_t;

    typedef struct packed {
        logic [1:0] pin_sync;
        logic       lat_hi;
    } sys_state_t;

    localparam link_state_t LINK_RST = '0;
    localparam sys_state_t  SYS_RST  = '0;

endpackage

// ---- burst_sram_dual_port_interface.sv ----
// Burst SRAM with separate read and write DDR ports on one shared address bus.
// Assumes link_clk_i rises once per DDR beat (K and K# edges merged), and
// that the controller drives all link inputs synchronous to link_clk_i.
`timescale 1ns/10ps

module burst_sram_dual_port_interface (
    input  wire logic                                clock_i,
    input  wire logic                                rst_n_i,
    input  wire logic                                link_clk_i,
    input  wire logic                                latency_select_pin_i,
    input  wire logic                                rd_sel_n_i,
    input  wire logic                                wr_sel_n_i,
    input  wire logic [sram_link_pkg::ADDR_W-1:0]    addr_i,
    input  wire logic [sram_link_pkg::LANES-1:0]     byte_write_selects_n_i,
    input  wire logic [sram_link_pkg::DATA_W-1:0]    wdata_i,
    output logic      [sram_link_pkg::DATA_W-1:0]    rdata_o,
    output logic                                     read_valid_flag_o,
    output logic                                     echo_clock_o,
    output logic                                     echo_clock_n_o
);

    localparam int DEPTH = (1 << sram_link_pkg::ADDR_W) * sram_link_pkg::BURST_LEN;

    sram_link_pkg::sys_state_t  sys_q;
    sram_link_pkg::sys_state_t  sys_d;
    sram_link_pkg::link_state_t st_q;
    sram_link_pkg::link_state_t st_d;

    logic [sram_link_pkg::DATA_W-1:0] mem [DEPTH];

    logic                              lat_hi;
    logic                              rd_start;
    logic                              wr_start;
    logic                              wr_commit;
    sram_link_pkg::rd_req_t            rd_due;
    logic [sram_link_pkg::DATA_W-1:0]  rd_word;
    logic [sram_link_pkg::ADDR_W-1:0]  rd_src_addr;
    logic [1:0]                        rd_src_idx;

    // Latency strap: pin -> system clock via three flops -> link clock via two flops.
    // Strap is static; changing it with reads in flight is not supported.
    always_comb begin
        sys_d          = sys_q;
        sys_d.pin_sync = {sys_q.pin_sync[0], latency_select_pin_i};
        sys_d.lat_hi   = sys_q.pin_sync[1];
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sys_q <= sram_link_pkg::SYS_RST;
        end else begin
            sys_q <= sys_d;
        end
    end

    assign lat_hi   = st_q.lat_sync[1];
    assign rd_start = st_q.in.rd_sel && (st_q.in.beat == sram_link_pkg::RD_SLOT);
    assign wr_start = st_q.in.wr_sel && (st_q.in.beat == sram_link_pkg::WR_SLOT);
    assign wr_commit = st_q.wr_act && (st_q.wr_idx == sram_link_pkg::LAST_WORD);
    assign rd_due   = lat_hi ? st_q.rd_pipe[sram_link_pkg::LAT_HI_BEATS-2]
                             : st_q.rd_pipe[sram_link_pkg::LAT_LO_BEATS-2];

    assign rd_src_addr = st_q.rd_act ? st_q.rd_addr : rd_due.addr;
    assign rd_src_idx  = st_q.rd_act ? st_q.rd_idx : 2'h0;

    function automatic logic [sram_link_pkg::DATA_W-1:0] merge_lanes(
        input logic [sram_link_pkg::DATA_W-1:0] old_w,
        input logic [sram_link_pkg::DATA_W-1:0] new_w,
        input logic [sram_link_pkg::LANES-1:0]  we
    );
        logic [sram_link_pkg::DATA_W-1:0] res;
        res = old_w;
        for (int l = 0; l < sram_link_pkg::LANES; l++) begin
            if (we[l]) begin
                res[l*sram_link_pkg::LANE_W +: sram_link_pkg::LANE_W] =
                    new_w[l*sram_link_pkg::LANE_W +: sram_link_pkg::LANE_W];
            end
        end
        return res;
    endfunction

    // Array word with forwarding from the write burst still being gathered,
    // so a read racing a write to the same address sees the newest bytes.
    always_comb begin
        rd_word = mem[{rd_src_addr, rd_src_idx}];
        if (st_q.wr_act && (st_q.wr_addr == rd_src_addr)) begin
            if (rd_src_idx < st_q.wr_idx) begin
                rd_word = merge_lanes(rd_word, st_q.wr_buf[rd_src_idx],
                                      st_q.wr_mask[rd_src_idx]);
            end else if (rd_src_idx == st_q.wr_idx) begin
                rd_word = merge_lanes(rd_word, st_q.in.data, st_q.in.lane_we);
            end
        end
    end

    always_comb begin
        st_d          = st_q;
        st_d.lat_sync = {st_q.lat_sync[0], sys_q.lat_hi};
        st_d.beat     = st_q.beat + 2'h1;
        st_d.echo     = ~st_q.echo;
        st_d.echo_n   = st_q.echo;

        // Every link input is registered before use
        st_d.in.rd_sel  = ~rd_sel_n_i;
        st_d.in.wr_sel  = ~wr_sel_n_i;
        st_d.in.addr    = addr_i;
        st_d.in.lane_we = ~byte_write_selects_n_i;
        st_d.in.data    = wdata_i;
        st_d.in.beat    = st_q.beat;

        // Read address pipe; tap chosen by the latency strap
        st_d.rd_pipe[0].valid = rd_start;
        st_d.rd_pipe[0].addr  = st_q.in.addr;
        for (int s = 1; s < sram_link_pkg::PIPE_LEN; s++) begin
            st_d.rd_pipe[s] = st_q.rd_pipe[s-1];
        end

        // Read burst: one registered word per beat
        st_d.rvalid = 1'b0;
        st_d.rdata  = '0;
        if (st_q.rd_act) begin
            st_d.rdata  = rd_word;
            st_d.rvalid = 1'b1;
            st_d.rd_idx = st_q.rd_idx + 2'h1;
            if (st_q.rd_idx == sram_link_pkg::LAST_WORD) begin
                st_d.rd_act = 1'b0;
            end
        end else if (rd_due.valid) begin
            st_d.rdata   = rd_word;
            st_d.rvalid  = 1'b1;
            st_d.rd_act  = 1'b1;
            st_d.rd_idx  = 2'h1;
            st_d.rd_addr = rd_due.addr;
        end

        // Write burst gathering; last word commits the whole burst
        if (st_q.wr_act) begin
            if (wr_commit) begin
                st_d.wr_act = 1'b0;
            end else begin
                st_d.wr_buf[st_q.wr_idx]  = st_q.in.data;
                st_d.wr_mask[st_q.wr_idx] = st_q.in.lane_we;
                st_d.wr_idx               = st_q.wr_idx + 2'h1;
            end
        end
        if (wr_start) begin
            st_d.wr_act  = 1'b1;
            st_d.wr_idx  = 2'h0;
            st_d.wr_addr = st_q.in.addr;
        end
    end

    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= sram_link_pkg::LINK_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Self-timed commit of all four words in one beat; no reset on storage
    always_ff @(posedge link_clk_i) begin
        if (wr_commit) begin
            for (int w = 0; w < sram_link_pkg::BURST_LEN; w++) begin
                if (w == sram_link_pkg::BURST_LEN - 1) begin
                    mem[{st_q.wr_addr, 2'(w)}] <= merge_lanes(
                        mem[{st_q.wr_addr, 2'(w)}], st_q.in.data, st_q.in.lane_we);
                end else begin
                    mem[{st_q.wr_addr, 2'(w)}] <= merge_lanes(
                        mem[{st_q.wr_addr, 2'(w)}], st_q.wr_buf[w], st_q.wr_mask[w]);
                end
            end
        end
    end

    assign rdata_o           = st_q.rdata;
    assign read_valid_flag_o = st_q.rvalid;
    assign echo_clock_o      = st_q.echo;
    assign echo_clock_n_o    = st_q.echo_n;

    default clocking cb @(posedge link_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_burst;
        st_q.rvalid [*4];
    endsequence

    sequence s_write_gather;
        st_q.wr_act && (st_q.wr_idx == 2'h0) ##3 wr_commit;
    endsequence

    // Previous burst must be over before the first word of the new one
    sequence s_first_word;
        !st_q.rd_act ##1 (st_q.rvalid && (st_q.rd_idx == 2'h1));
    endsequence

    property p_lat_hi;
        (rd_start && lat_hi && $stable(lat_hi)) |-> ##4 s_first_word;
    endproperty
    a_lat_hi: assert property (p_lat_hi)
        else $error("read data late or early, long latency");

    property p_lat_lo;
        (rd_start && !lat_hi && $stable(lat_hi)) |-> ##1 s_first_word;
    endproperty
    a_lat_lo: assert property (p_lat_lo)
        else $error("read data late or early, short latency");

    property p_burst_len;
        $rose(st_q.rvalid) |-> s_burst;
    endproperty
    a_burst_len: assert property (p_burst_len)
        else $error("read burst shorter than four words");

    property p_write_slot;
        wr_start |=> st_q.wr_act && (st_q.wr_idx == 2'h0)
                     && (st_q.wr_addr == $past(st_q.in.addr));
    endproperty
    a_write_slot: assert property (p_write_slot)
        else $error("write address not taken in its slot");

    property p_write_commit;
        wr_start |=> s_write_gather;
    endproperty
    a_write_commit: assert property (p_write_commit)
        else $error("write burst not committed on time");

    // First edge after release still sees the reset values
    property p_echo;
        $past(rst_n_i) |-> (echo_clock_o != $past(echo_clock_o))
                           && (echo_clock_n_o == !echo_clock_o);
    endproperty
    a_echo: assert property (p_echo)
        else $error("echo clocks not complementary toggling");

    property p_unselected;
        (st_q.in.beat == sram_link_pkg::RD_SLOT && !st_q.in.rd_sel && lat_hi
         && $stable(lat_hi) && !st_q.rd_act && !st_q.rd_pipe[0].valid
         && !st_q.rd_pipe[1].valid && !st_q.rd_pipe[2].valid && !st_q.rd_pipe[3].valid)
        |-> ##5 !st_q.rvalid;
    endproperty
    a_unselected: assert property (p_unselected)
        else $error("read data without port select");

    property p_valid_end;
        $fell(st_q.rvalid) |-> ($past(st_q.rd_idx) == 2'h0) && !$past(st_q.rd_act);
    endproperty
    a_valid_end: assert property (p_valid_end)
        else $error("read valid dropped inside a burst");

    // Read slot, read select and capture checks run on every beat; write slot and select checks only while no write burst is open

    property p_read_slot;
        (st_q.in.beat != sram_link_pkg::RD_SLOT) |=> !st_q.rd_pipe[0].valid;
    endproperty
    a_read_slot: assert property (p_read_slot)
        else $error("read address taken outside its slot");

    property p_write_slot_only;
        (st_q.in.beat != sram_link_pkg::WR_SLOT && !st_q.wr_act) |=> !st_q.wr_act;
    endproperty
    a_write_slot_only: assert property (p_write_slot_only)
        else $error("write address taken outside its slot");

    property p_read_unselected;
        (st_q.in.beat == sram_link_pkg::RD_SLOT && !st_q.in.rd_sel) |=> !st_q.rd_pipe[0].valid;
    endproperty
    a_read_unselected: assert property (p_read_unselected)
        else $error("read taken without port select");

    property p_write_unselected;
        (st_q.in.beat == sram_link_pkg::WR_SLOT && !st_q.in.wr_sel && !st_q.wr_act)
        |=> !st_q.wr_act;
    endproperty
    a_write_unselected: assert property (p_write_unselected)
        else $error("write taken without port select");

    property p_beat_step;
        $past(rst_n_i) |-> (st_q.beat == $past(st_q.beat) + 2'h1);
    endproperty
    a_beat_step: assert property (p_beat_step)
        else $error("beat counter skipped a link edge");

    property p_input_regs;
        $past(rst_n_i) |-> (st_q.in.addr == $past(addr_i))
                           && (st_q.in.data == $past(wdata_i))
                           && (st_q.in.lane_we == ~$past(byte_write_selects_n_i));
    endproperty
    a_input_regs: assert property (p_input_regs)
        else $error("link inputs not held in input registers");

    sequence s_read_run;
        (st_q.rd_act && (st_q.rd_idx == 2'h1)) ##1 (st_q.rd_act && (st_q.rd_idx == 2'h2))
        ##1 (st_q.rd_act && (st_q.rd_idx == 2'h3)) ##1 !st_q.rd_act;
    endsequence

    property p_read_run;
        $rose(st_q.rd_act) |-> s_read_run;
    endproperty
    a_read_run: assert property (p_read_run)
        else $error("read burst words out of order");

    property p_due_starts;
        (rd_due.valid && !st_q.rd_act)
        |=> st_q.rvalid && st_q.rd_act && (st_q.rd_addr == $past(rd_due.addr));
    endproperty
    a_due_starts: assert property (p_due_starts)
        else $error("due read did not start its burst");

    property p_valid_source;
        st_q.rvalid |-> $past(st_q.rd_act) || $past(rd_due.valid);
    endproperty
    a_valid_source: assert property (p_valid_source)
        else $error("read valid without a pending read");

    property p_rdata_idle;
        !st_q.rvalid |-> (st_q.rdata == '0);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not cleared between bursts");

    property p_write_step;
        (st_q.wr_act && !wr_commit)
        |=> st_q.wr_act && (st_q.wr_idx == $past(st_q.wr_idx) + 2'h1)
            && (st_q.wr_buf[$past(st_q.wr_idx)] == $past(st_q.in.data));
    endproperty
    a_write_step: assert property (p_write_step)
        else $error("write word not gathered on its beat");

    property p_commit_ends;
        (wr_commit && !wr_start) |=> !st_q.wr_act;
    endproperty
    a_commit_ends: assert property (p_commit_ends)
        else $error("write burst still open after commit");

    property p_concurrent;
        (st_q.rd_act && st_q.wr_act) |=> st_q.rvalid && (st_q.wr_act || $past(wr_commit));
    endproperty
    a_concurrent: assert property (p_concurrent)
        else $error("read and write bursts stalled each other");

endmodule

// ---- sram_ctrl_model.sv ----
// Memory controller model driving the link pins, one beat per link edge.
// Assumes the block samples beat 0 at the first link edge after reset release.
`timescale 1ns/10ps

module sram_ctrl_model (
    input  wire logic                                link_clk_i,
    input  wire logic                                rst_n_i,
    output logic                                     rd_sel_n_o,
    output logic                                     wr_sel_n_o,
    output logic      [sram_link_pkg::ADDR_W-1:0]    addr_o,
    output logic      [sram_link_pkg::LANES-1:0]     byte_write_selects_n_o,
    output logic      [sram_link_pkg::DATA_W-1:0]    wdata_o
);
    logic                                    rd_go = 1'b0;
    logic                                    wr_go = 1'b0;
    logic [sram_link_pkg::ADDR_W-1:0]        rd_a;
    logic [sram_link_pkg::ADDR_W-1:0]        wr_a;
    logic [3:0][sram_link_pkg::DATA_W-1:0]   wd;
    logic [sram_link_pkg::LANES-1:0]         mask_n;
    logic [1:0]                              nxt;
    int                                      wi;

    always @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            nxt                    <= 2'h1;
            wi                     <= 4;
            rd_sel_n_o             <= 1'b1;
            wr_sel_n_o             <= 1'b1;
            addr_o                 <= '0;
            byte_write_selects_n_o <= '1;
            wdata_o                <= '0;
        end else begin
            nxt                    <= nxt + 2'h1;
            rd_sel_n_o             <= 1'b1;
            wr_sel_n_o             <= 1'b1;
            // Released lines never repeat their last value
            addr_o                 <= ~addr_o;
            wdata_o                <= ~wdata_o;
            byte_write_selects_n_o <= ~byte_write_selects_n_o;
            // Data before address so a back-to-back write restarts the count
            if (wi < 4) begin
                wdata_o                <= wd[wi];
                byte_write_selects_n_o <= mask_n;
                wi                     <= wi + 1;
            end
            if (nxt == 2'h0 && rd_go) begin
                rd_sel_n_o <= 1'b0;
                addr_o     <= rd_a;
                rd_go      <= 1'b0;
            end
            if (nxt == 2'h2 && wr_go) begin
                wr_sel_n_o <= 1'b0;
                addr_o     <= wr_a;
                wr_go      <= 1'b0;
                wi         <= 0;
            end
        end
    end
endmodule

// ---- test_burst_sram_dual_port_interface.sv ----
// Self-checking bench for the burst SRAM link block.
// Assumes the controller model above drives every link input.
`timescale 1ns/10ps

module test_burst_sram_dual_port_interface;
    logic              clock_i = 1'b0;
    logic              rst_n_i = 1'b0;
    logic              link_clk_i = 1'b0;
    logic              lat_pin = 1'b1;
    logic              rd_sel_n, wr_sel_n, rvalid, echo, echo_n;
    logic [7:0]        addr;
    logic [3:0]        bws_n;
    logic [35:0]       wdata, rdata;
    logic [3:0][35:0]  lx;
    int                errors = 0;
    int                checks = 0;
    localparam logic [3:0][35:0] D1 = {36'hD_DDDD_DDD3, 36'hC_CCCC_CCC2,
                                       36'hB_BBBB_BBB1, 36'hA_AAAA_AAA0};
    localparam logic [3:0][35:0] D2 = {36'h0_1234_5678, 36'h8_7654_3210,
                                       36'hF_0F0F_0F0F, 36'h5_A5A5_A5A5};

    burst_sram_dual_port_interface uut (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .link_clk_i(link_clk_i), .latency_select_pin_i(lat_pin), .rd_sel_n_i(rd_sel_n),
        .wr_sel_n_i(wr_sel_n), .addr_i(addr), .byte_write_selects_n_i(bws_n),
        .wdata_i(wdata), .rdata_o(rdata), .read_valid_flag_o(rvalid),
        .echo_clock_o(echo), .echo_clock_n_o(echo_n));
    sram_ctrl_model ctl (.link_clk_i(link_clk_i), .rst_n_i(rst_n_i), .rd_sel_n_o(rd_sel_n),
        .wr_sel_n_o(wr_sel_n), .addr_o(addr), .byte_write_selects_n_o(bws_n),
        .wdata_o(wdata));

    initial forever #4 clock_i = ~clock_i;
    initial begin
        #37;
        forever #80 link_clk_i = ~link_clk_i;
    end

    task automatic cmp(string what, logic [35:0] exp, logic [35:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr(logic [7:0] a, logic [3:0][35:0] d, logic [3:0] m);
        @(negedge link_clk_i);
        ctl.wr_a = a;
        ctl.wd = d;
        ctl.mask_n = m;
        ctl.wr_go = 1'b1;
        do @(negedge link_clk_i); while (ctl.wr_go || ctl.wi < 4);
    endtask

    // Counts edges from the one that drives the address to the first valid word
    task automatic rd(logic [7:0] a, int lat, logic [3:0][35:0] exp);
        int n;
        @(negedge link_clk_i);
        ctl.rd_a = a;
        ctl.rd_go = 1'b1;
        while (ctl.rd_go) @(negedge link_clk_i);
        n = 0;
        do begin
            @(negedge link_clk_i);
            n++;
        end while (rvalid !== 1'b1 && n < 12);
        cmp("latency", 36'(lat + 1), 36'(n));
        for (int i = 0; i < 4; i++) begin
            if (i > 0) @(negedge link_clk_i);
            cmp("read_word", exp[i], rdata);
            cmp("valid", 36'h1, 36'(rvalid));
        end
        @(negedge link_clk_i);
        cmp("valid_end", 36'h0, 36'(rvalid));
    endtask

    task automatic t_hi();
        logic e;
        wr(8'h11, D1, 4'h0);
        rd(8'h11, 5, D1);
        e = echo;
        @(negedge link_clk_i);
        cmp("echo_toggle", {35'h0, ~e}, 36'(echo));
        cmp("echo_pair", {35'h0, ~echo}, 36'(echo_n));
    endtask

    task automatic t_lanes();
        for (int i = 0; i < 4; i++)
            for (int l = 0; l < 4; l++)
                lx[i][9*l +: 9] = l[0] ? D2[0][9*l +: 9] : D1[i][9*l +: 9];
        wr(8'h11, {4{D2[0]}}, 4'h5);
        rd(8'h11, 5, lx);
    endtask

    task automatic t_conc();
        @(negedge link_clk_i);
        ctl.wr_a = 8'h22;
        ctl.wd = D2;
        ctl.mask_n = 4'h0;
        ctl.wr_go = 1'b1;
        rd(8'h11, 5, lx);
        rd(8'h22, 5, D2);
    endtask

    task automatic t_idle();
        int seen = 0;
        repeat (12) begin
            @(negedge link_clk_i);
            seen += int'(rvalid === 1'b1);
        end
        cmp("idle_valid", 36'h0, 36'(seen));
    endtask

    task automatic t_lo();
        @(posedge clock_i) lat_pin <= 1'b0;
        repeat (8) @(negedge link_clk_i);
        rd(8'h22, 2, D2);
        // Read issued two beats after the write address: first two words come from the pending burst, last two from the committed array
        ctl.wr_a = 8'h33;
        ctl.wd = D1;
        ctl.mask_n = 4'h0;
        ctl.wr_go = 1'b1;
        while (ctl.wr_go) @(negedge link_clk_i);
        rd(8'h33, 2, D1);
    endtask

    initial begin
        #100000;
        errors++;
        end_of_test();
    end

    initial begin
        repeat (10) @(posedge link_clk_i);
        @(posedge clock_i) rst_n_i <= 1'b1;
        repeat (8) @(negedge link_clk_i);
        t_hi();
        t_lanes();
        t_conc();
        t_idle();
        t_lo();
        end_of_test();
    end
endmodule
